// *** ibm_consts.svh ***
// Constants of the input boost mixer control block: offsets, field positions, resets.
// Assumes inclusion by bare name from the package and the design file.
`ifndef IBM_CONSTS_SVH
`define IBM_CONSTS_SVH
`define IBM_ADDR_W 8
`define IBM_DATA_W 9
`define IBM_OFS_ENA_MUTE 8'h1f
`define IBM_OFS_LEFT_GAINS 8'h20
`define IBM_OFS_RIGHT_GAINS 8'h21
`define IBM_OFS_PATH_SEL 8'h22
`define IBM_BIT_LEFT_MUTE 3
`define IBM_BIT_RIGHT_MUTE 2
`define IBM_BIT_LEFT_ENA 1
`define IBM_BIT_RIGHT_ENA 0
`define IBM_MSB_SECOND 8
`define IBM_LSB_SECOND 6
`define IBM_MSB_PREAMP 5
`define IBM_LSB_PREAMP 3
`define IBM_MSB_THIRD 2
`define IBM_LSB_THIRD 0
`define IBM_BIT_L_SECOND_SEL 5
`define IBM_BIT_L_THIRD_SEL 4
`define IBM_BIT_L_PREAMP_SEL 3
`define IBM_BIT_R_SECOND_SEL 2
`define IBM_BIT_R_THIRD_SEL 1
`define IBM_BIT_R_PREAMP_SEL 0
`define IBM_RST_LINE_GAIN 3'h5
`define IBM_RST_PREAMP_GAIN 3'h0
`define IBM_RST_LINE_SEL 1'h0
`define IBM_RST_PREAMP_SEL 1'h1
`endif

// *** ibm_pkg.sv ***
// Types of the input boost mixer control block.
// Assumes the constants header is on the include path.
`default_nettype none
package ibm_pkg;
`include "ibm_consts.svh"
    typedef struct packed {
        logic enable;
        logic mute;
        logic second_select;
        logic third_select;
        logic preamp_select;
        logic [2:0] second_gain;
        logic [2:0] third_gain;
        logic [2:0] preamp_gain;
    } ibm_mixer_t;

    typedef struct packed {
        logic left_ena_bit;
        logic right_ena_bit;
        logic left_mute;
        logic right_mute;
        logic [2:0] l_second_gain;
        logic [2:0] l_preamp_gain;
        logic [2:0] l_third_gain;
        logic [2:0] r_second_gain;
        logic [2:0] r_preamp_gain;
        logic [2:0] r_third_gain;
        logic l_second_sel;
        logic l_third_sel;
        logic l_preamp_sel;
        logic r_second_sel;
        logic r_third_sel;
        logic r_preamp_sel;
        logic left_path_sync1;
        logic left_path_sync2;
        logic right_path_sync1;
        logic right_path_sync2;
        logic [`IBM_DATA_W-1:0] rdata;
        ibm_mixer_t left_out;
        ibm_mixer_t right_out;
    } ibm_state_t;
endpackage : ibm_pkg
`default_nettype wire

// *** ibm_input_boost_mixer_control.sv ***
// Register bank for the left and right analogue input boost mixers.
// Assumes a plain register port on clk_sys and input-path enables from another domain.
`default_nettype none
`include "ibm_consts.svh"

module ibm_input_boost_mixer_control
    import ibm_pkg::*;
(
    input wire logic clk_sys, // System clock, 100 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic [`IBM_ADDR_W-1:0] reg_addr, // Register address.
    input wire logic [`IBM_DATA_W-1:0] reg_wdata, // Write data.
    input wire logic reg_write, // Write strobe.
    input wire logic reg_read, // Read strobe.
    output logic [`IBM_DATA_W-1:0] reg_rdata, // Read data, one cycle after the strobe.
    input wire logic left_input_path_enable, // Left input path enable.
    input wire logic right_input_path_enable, // Right input path enable.
    output ibm_mixer_t left_boost_mixer, // Left mixer controls.
    output ibm_mixer_t right_boost_mixer // Right mixer controls.
);

    ibm_state_t state_reg;
    ibm_state_t state_next;

    // Mixer controls are static levels; gains may step while a path is live.
    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = '0;
        state_next.left_path_sync1 = left_input_path_enable;
        state_next.left_path_sync2 = state_reg.left_path_sync1;
        state_next.right_path_sync1 = right_input_path_enable;
        state_next.right_path_sync2 = state_reg.right_path_sync1;
        if (reg_write)
        begin
            unique case (reg_addr)
                `IBM_OFS_ENA_MUTE:
                begin
                    state_next.left_mute = reg_wdata[`IBM_BIT_LEFT_MUTE];
                    state_next.right_mute = reg_wdata[`IBM_BIT_RIGHT_MUTE];
                    state_next.left_ena_bit = reg_wdata[`IBM_BIT_LEFT_ENA];
                    state_next.right_ena_bit = reg_wdata[`IBM_BIT_RIGHT_ENA];
                end
                `IBM_OFS_LEFT_GAINS:
                begin
                    state_next.l_second_gain = reg_wdata[`IBM_MSB_SECOND:`IBM_LSB_SECOND];
                    state_next.l_preamp_gain = reg_wdata[`IBM_MSB_PREAMP:`IBM_LSB_PREAMP];
                    state_next.l_third_gain = reg_wdata[`IBM_MSB_THIRD:`IBM_LSB_THIRD];
                end
                `IBM_OFS_RIGHT_GAINS:
                begin
                    state_next.r_second_gain = reg_wdata[`IBM_MSB_SECOND:`IBM_LSB_SECOND];
                    state_next.r_preamp_gain = reg_wdata[`IBM_MSB_PREAMP:`IBM_LSB_PREAMP];
                    state_next.r_third_gain = reg_wdata[`IBM_MSB_THIRD:`IBM_LSB_THIRD];
                end
                `IBM_OFS_PATH_SEL:
                begin
                    state_next.l_second_sel = reg_wdata[`IBM_BIT_L_SECOND_SEL];
                    state_next.l_third_sel = reg_wdata[`IBM_BIT_L_THIRD_SEL];
                    state_next.l_preamp_sel = reg_wdata[`IBM_BIT_L_PREAMP_SEL];
                    state_next.r_second_sel = reg_wdata[`IBM_BIT_R_SECOND_SEL];
                    state_next.r_third_sel = reg_wdata[`IBM_BIT_R_THIRD_SEL];
                    state_next.r_preamp_sel = reg_wdata[`IBM_BIT_R_PREAMP_SEL];
                end
                default:
                begin
                end
            endcase
        end
        if (reg_read)
        begin
            unique case (reg_addr)
                `IBM_OFS_ENA_MUTE:
                begin
                    state_next.rdata[`IBM_BIT_LEFT_MUTE] = state_reg.left_mute;
                    state_next.rdata[`IBM_BIT_RIGHT_MUTE] = state_reg.right_mute;
                    state_next.rdata[`IBM_BIT_LEFT_ENA] = state_reg.left_ena_bit;
                    state_next.rdata[`IBM_BIT_RIGHT_ENA] = state_reg.right_ena_bit;
                end
                `IBM_OFS_LEFT_GAINS:
                    state_next.rdata = {state_reg.l_second_gain, state_reg.l_preamp_gain,
                        state_reg.l_third_gain};
                `IBM_OFS_RIGHT_GAINS:
                    state_next.rdata = {state_reg.r_second_gain, state_reg.r_preamp_gain,
                        state_reg.r_third_gain};
                `IBM_OFS_PATH_SEL:
                    state_next.rdata = {3'h0, state_reg.l_second_sel, state_reg.l_third_sel,
                        state_reg.l_preamp_sel, state_reg.r_second_sel,
                        state_reg.r_third_sel, state_reg.r_preamp_sel};
                default:
                    state_next.rdata = '0;
            endcase
        end
        // Outputs follow the stored fields with no update latch.
        state_next.left_out.enable = state_next.left_ena_bit | state_reg.left_path_sync2;
        state_next.left_out.mute = state_next.left_mute;
        state_next.left_out.second_select = state_next.l_second_sel;
        state_next.left_out.third_select = state_next.l_third_sel;
        state_next.left_out.preamp_select = state_next.l_preamp_sel;
        state_next.left_out.second_gain = state_next.l_second_gain;
        state_next.left_out.third_gain = state_next.l_third_gain;
        state_next.left_out.preamp_gain = state_next.l_preamp_gain;
        state_next.right_out.enable = state_next.right_ena_bit | state_reg.right_path_sync2;
        state_next.right_out.mute = state_next.right_mute;
        state_next.right_out.second_select = state_next.r_second_sel;
        state_next.right_out.third_select = state_next.r_third_sel;
        state_next.right_out.preamp_select = state_next.r_preamp_sel;
        state_next.right_out.second_gain = state_next.r_second_gain;
        state_next.right_out.third_gain = state_next.r_third_gain;
        state_next.right_out.preamp_gain = state_next.r_preamp_gain;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= '0;
            state_reg.l_second_gain <= `IBM_RST_LINE_GAIN;
            state_reg.l_third_gain <= `IBM_RST_LINE_GAIN;
            state_reg.l_preamp_gain <= `IBM_RST_PREAMP_GAIN;
            state_reg.r_second_gain <= `IBM_RST_LINE_GAIN;
            state_reg.r_third_gain <= `IBM_RST_LINE_GAIN;
            state_reg.r_preamp_gain <= `IBM_RST_PREAMP_GAIN;
            state_reg.l_second_sel <= `IBM_RST_LINE_SEL;
            state_reg.l_third_sel <= `IBM_RST_LINE_SEL;
            state_reg.l_preamp_sel <= `IBM_RST_PREAMP_SEL;
            state_reg.r_second_sel <= `IBM_RST_LINE_SEL;
            state_reg.r_third_sel <= `IBM_RST_LINE_SEL;
            state_reg.r_preamp_sel <= `IBM_RST_PREAMP_SEL;
            state_reg.left_out.second_gain <= `IBM_RST_LINE_GAIN;
            state_reg.left_out.third_gain <= `IBM_RST_LINE_GAIN;
            state_reg.left_out.preamp_gain <= `IBM_RST_PREAMP_GAIN;
            state_reg.left_out.preamp_select <= `IBM_RST_PREAMP_SEL;
            state_reg.right_out.second_gain <= `IBM_RST_LINE_GAIN;
            state_reg.right_out.third_gain <= `IBM_RST_LINE_GAIN;
            state_reg.right_out.preamp_gain <= `IBM_RST_PREAMP_GAIN;
            state_reg.right_out.preamp_select <= `IBM_RST_PREAMP_SEL;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign left_boost_mixer = state_reg.left_out;
    assign right_boost_mixer = state_reg.right_out;

endmodule : ibm_input_boost_mixer_control
`default_nettype wire

// *** ibm_mixer_model.sv ***
// Behavioural model of the analogue left and right input boost mixers.
// Assumes the control block drives both mixer control structs on clk_sys.
`default_nettype none
module ibm_mixer_model
    import ibm_pkg::*;
(
    input wire logic clk_sys, // Register clock.
    input wire ibm_mixer_t left_boost_mixer, // Left mixer controls.
    input wire ibm_mixer_t right_boost_mixer, // Right mixer controls.
    output var int pops // Gain or mute changes seen on a live mixer.
);
    ibm_mixer_t l_q;
    ibm_mixer_t r_q;
    initial pops = 0;
    // A gain or mute step on an enabled mixer would be heard as a pop.
    always @(posedge clk_sys)
    begin
        if (l_q.enable && {l_q.mute, l_q[8:0]} !== {left_boost_mixer.mute, left_boost_mixer[8:0]})
            pops++;
        if (r_q.enable && {r_q.mute, r_q[8:0]} !== {right_boost_mixer.mute, right_boost_mixer[8:0]})
            pops++;
        l_q <= left_boost_mixer;
        r_q <= right_boost_mixer;
    end
endmodule // ibm_mixer_model
`default_nettype wire

// *** ibm_input_boost_mixer_control_asserts.sv ***
// Concurrent checks on the ports of the input boost mixer control block.
// Assumes it is bound to the block and sees only the block's ports.
`default_nettype none
module ibm_mixer_asserts
    import ibm_pkg::*;
(
    input wire logic clk_sys, // Register clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic [7:0] reg_addr, // Register address.
    input wire logic [8:0] reg_wdata, // Write data.
    input wire logic reg_write, // Write strobe.
    input wire logic reg_read, // Read strobe.
    input wire logic [8:0] reg_rdata, // Read data.
    input wire logic left_input_path_enable, // Left path enable.
    input wire logic right_input_path_enable, // Right path enable.
    input wire ibm_mixer_t left_boost_mixer, // Left mixer controls.
    input wire ibm_mixer_t right_boost_mixer // Right mixer controls.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_read_idle: assert property (
        !$past(reg_read) |-> reg_rdata == 9'h000) else $error("read data not idle");
    a_left_gains: assert property (
        reg_write && reg_addr == 8'h20 |=> left_boost_mixer[8:0] ==
        {$past(reg_wdata[8:6]), $past(reg_wdata[2:0]), $past(reg_wdata[5:3])})
        else $error("left gains not applied");
    a_right_gains: assert property (
        reg_write && reg_addr == 8'h21 |=> right_boost_mixer[8:0] ==
        {$past(reg_wdata[8:6]), $past(reg_wdata[2:0]), $past(reg_wdata[5:3])})
        else $error("right gains not applied");
    a_mute_write: assert property (
        reg_write && reg_addr == 8'h1f |=> left_boost_mixer.mute == $past(reg_wdata[3])
        && right_boost_mixer.mute == $past(reg_wdata[2])) else $error("mute not applied");
    a_select_write: assert property (
        reg_write && reg_addr == 8'h22 |=> {left_boost_mixer[11:9], right_boost_mixer[11:9]}
        == $past(reg_wdata[5:0])) else $error("selects not applied");
    a_left_path: assert property (
        left_input_path_enable [*4] |=> left_boost_mixer.enable) else $error("left enable");
    a_right_path: assert property (
        right_input_path_enable [*4] |=> right_boost_mixer.enable) else $error("right enable");
    a_unmapped_read: assert property (
        reg_read && (reg_addr > 8'h22 || reg_addr < 8'h1f) |=> reg_rdata == 9'h000)
        else $error("unmapped read not zero");
    c_gain_write: cover property (reg_write && reg_addr == 8'h20);
    c_path_on: cover property (right_input_path_enable [*4]);
    c_select_read: cover property (reg_read && reg_addr == 8'h22);
endmodule // ibm_mixer_asserts
bind ibm_input_boost_mixer_control ibm_mixer_asserts u_asserts (.clk_sys(clk_sys),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .left_input_path_enable(left_input_path_enable),
    .right_input_path_enable(right_input_path_enable), .left_boost_mixer(left_boost_mixer),
    .right_boost_mixer(right_boost_mixer));
`default_nettype wire

// *** tb_input_boost_mixer_control.sv ***
// Self-checking bench for the input boost mixer control block.
// Assumes the package, the block, the mixer model and the checker are compiled first.
`default_nettype none
module tb_input_boost_mixer_control
    import ibm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [8:0] reg_wdata = 9'h000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic lpe = 1'b0;
    logic rpe = 1'b0;
    logic [8:0] reg_rdata;
    ibm_mixer_t lm;
    ibm_mixer_t rm;
    int pops;
    int fails = 0;
    int num_checks = 0;
    always #5 clk_sys = ~clk_sys;
    ibm_input_boost_mixer_control dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .left_input_path_enable(lpe), .right_input_path_enable(rpe), .left_boost_mixer(lm),
        .right_boost_mixer(rm));
    ibm_mixer_model u_mix (.clk_sys(clk_sys), .left_boost_mixer(lm), .right_boost_mixer(rm),
        .pops(pops));
    task automatic chk(input string n, input logic [14:0] seen, input logic [14:0] exp);
        if (seen !== exp)
        begin
            $display("BAD %s exp %h seen %h", n, exp, seen);
            fails++;
        end
        num_checks++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [8:0] d);
        @(posedge clk_sys);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        @(posedge clk_sys);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 chk("rdata", 15'(reg_rdata), 15'(e));
    endtask
    task automatic paths(input logic l, input logic r);
        @(posedge clk_sys);
        {lpe, rpe} <= {l, r};
        repeat (3) @(posedge clk_sys);
        #1 chk("enables", {lm.enable, rm.enable}, {l, r});
    endtask
    task automatic t_gains();
        for (int i = 0; i < 8; i++)
        begin
            logic [2:0] c = 3'(i);
            wr(8'h20, {c, ~c, c + 3'h1});
            chk("left", lm, {5'h01, c, c + 3'h1, ~c});
            wr(8'h21, {~c, c, c + 3'h1});
            chk("right", rm, {5'h01, ~c, c + 3'h1, c});
            rd(8'h20, {c, ~c, c + 3'h1});
        end
        $display("t_gains done");
    endtask
    task automatic t_mute_sel();
        wr(8'h1f, 9'h1fc);
        rd(8'h1f, 9'h00c);
        wr(8'h22, 9'h1e5);
        rd(8'h22, 9'h025);
        chk("flags", 15'({lm[13:9], rm[13:9]}), 15'({5'h0c, 5'h0d}));
        $display("t_mute_sel done");
    endtask
    task automatic t_ena();
        wr(8'h1f, 9'h002);
        chk("bits", {lm.enable, rm.enable, lm.mute, rm.mute}, 4'h8);
        wr(8'h1f, 9'h000);
        paths(1'b0, 1'b1);
        paths(1'b1, 1'b0);
        rd(8'h1f, 9'h000);
        paths(1'b0, 1'b0);
        $display("t_ena done");
    endtask
    task automatic t_unmapped();
        wr(8'h23, 9'h1ff);
        wr(8'h1e, 9'h1ff);
        chk("kept", lm, {5'h04, 9'h1c0});
        rd(8'h23, 9'h000);
        rd(8'h1e, 9'h000);
        $display("t_unmapped done");
    endtask
    task automatic finish_test();
        chk("pops", 15'(pops), 15'h0000);
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        #1 chk("left reset", lm, {5'h01, 9'h168});
        chk("right reset", rm, {5'h01, 9'h168});
        rd(8'h1f, 9'h000);
        rd(8'h21, 9'h145);
        rd(8'h22, 9'h009);
        t_gains();
        t_mute_sel();
        t_ena();
        t_unmapped();
        finish_test();
    end
endmodule // tb_input_boost_mixer_control
`default_nettype wire
